// ==== inc/smcg_pkg.sv ====
// Package for the sleep mode clock gating block
package smcg_pkg;

   // ****************************************
   // Mode field encodings
   // ****************************************
   localparam logic [2:0] SMCG_MODE_IDLE    = 3'h0;
   localparam logic [2:0] SMCG_MODE_ADCNR   = 3'h1;
   localparam logic [2:0] SMCG_MODE_PDOWN   = 3'h2;
   localparam logic [2:0] SMCG_MODE_PSAVE   = 3'h3;
   localparam logic [2:0] SMCG_MODE_STBY    = 3'h6;
   localparam logic [2:0] SMCG_MODE_XSTBY   = 3'h7;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned SMCG_CLK_MHZ      = 250;
   // Oscillator start-up time in microseconds
   localparam int unsigned SMCG_OSC_START_US = 16;
   localparam int unsigned SMCG_OSC_START_CYC = SMCG_OSC_START_US * SMCG_CLK_MHZ;
   localparam int unsigned SMCG_CNT_W        = 16;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [2:0] SMCG_MODE_RST = 3'h0;

   typedef enum logic [1:0] {
      SMCG_RUN,
      SMCG_SLEEP,
      SMCG_START
   } smcg_state_t;

endpackage

// ==== design/smcg_sync.sv ====
// Two-flop synchroniser for a group of pin-level inputs
module smcg_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ==== design/smcg_top.sv ====
// Sleep mode controller: clock domain gating and wake-up sequencing
//
// Behaviour
// - Six selectable sleep modes; software picks the one entered on sleep.
// - Idle halts only the processor clock; memory, timers, serial, interrupts run.
// - Power-down stops the oscillator and all functions, keeping register contents.
// - Power-down exits only on interrupt or hardware reset.
// - Power-save is power-down with the asynchronous timer still running.
// - ADC noise reduction runs only the oscillator, asynchronous timer and ADC.
// - Standby keeps the main oscillator running while everything else sleeps.
// - Extended standby keeps oscillator and asynchronous timer running.
module smcg_top
   import smcg_pkg::*;
#(
   parameter int unsigned OSC_START_CYC = SMCG_OSC_START_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] sleep_mode,
   input  wire logic       sleep_en,
   input  wire logic       sleep_req,
   input  wire logic       irq_async,
   input  wire logic       irq_sync,
   input  wire logic       timer_async_irq,
   input  wire logic       adc_done,
   output logic            cpu_clk_en,
   output logic            io_clk_en,
   output logic            adc_clk_en,
   output logic            tmr_async_clk_en,
   output logic            osc_en,
   output logic            cpu_resume,
   output logic            asleep
);

   // ****************************************
   // Input synchronisation
   // ****************************************
   // The pin interrupt comes from outside the clock domain; two flops guard
   // against metastability, so a pin wake is seen two cycles after the pin.
   logic irq_async_s;

   smcg_sync #(.W(1)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (irq_async),
      .q   (irq_async_s)
   );

   // ****************************************
   // Mode decode
   // ****************************************
   smcg_state_t state_r;
   smcg_state_t state_nxt;
   logic [2:0]  mode_r;
   logic [2:0]  mode_sel;
   logic [SMCG_CNT_W-1:0] cnt_r;
   logic [SMCG_CNT_W-1:0] cnt_nxt;

   wire mode_known = (sleep_mode == SMCG_MODE_IDLE)  || (sleep_mode == SMCG_MODE_ADCNR) ||
                     (sleep_mode == SMCG_MODE_PDOWN) || (sleep_mode == SMCG_MODE_PSAVE) ||
                     (sleep_mode == SMCG_MODE_STBY)  || (sleep_mode == SMCG_MODE_XSTBY);
   // Unused codes fall back to idle, the mildest mode, so a bad field never stops the clock
   assign mode_sel = mode_known ? sleep_mode : SMCG_MODE_IDLE;
   wire enter = sleep_req && sleep_en;

   // ****************************************
   // Latched mode decode
   // ****************************************
   // Valid in sleep and start-up; on the entry edge the entry decode is used
   // per-mode domain selection
   wire m_idle  = (mode_r == SMCG_MODE_IDLE);
   wire m_adcnr = (mode_r == SMCG_MODE_ADCNR);
   wire m_psave = (mode_r == SMCG_MODE_PSAVE);
   wire m_stby  = (mode_r == SMCG_MODE_STBY);
   wire m_xstby = (mode_r == SMCG_MODE_XSTBY);

   // idle keeps the I/O domain clocked
   wire keep_io  = m_idle;
   // noise reduction keeps the ADC running
   wire keep_adc = m_idle || m_adcnr;
   wire keep_tmr = m_idle || m_adcnr || m_psave || m_xstby;
   // oscillator stops only in power-down and power-save
   wire keep_osc = m_idle || m_adcnr || m_stby || m_xstby;

   // ****************************************
   // Wake sources
   // ****************************************
   // A source whose block is stopped is ignored, so a stale request from a
   // gated block cannot end a deep sleep early.
   // only an interrupt wakes deep modes; reset is the other exit
   wire deep_wake  = irq_async_s || (keep_tmr && timer_async_irq);

   wire wake_idle  = irq_sync || adc_done || deep_wake;
   wire wake_adcnr = adc_done || deep_wake;
   wire wake       = keep_io  ? wake_idle  :
                     keep_adc ? wake_adcnr : deep_wake;

   // ****************************************
   // Sleep sequencer
   // ****************************************
   // Requests while asleep or starting are ignored: the processor is stopped
   // then, so such a request can only be a glitch. Reset ends any state at
   // once and restores every enable, the other exit from power-down.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         SMCG_RUN: begin
            if (enter) begin
               state_nxt = SMCG_SLEEP;
            end
         end
         SMCG_SLEEP: begin
            if (wake) begin
               state_nxt = SMCG_START;
               // A kept oscillator needs no settling, so the count starts at zero
               cnt_nxt   = keep_osc ? '0 : SMCG_CNT_W'(OSC_START_CYC);
            end
         end
         SMCG_START: begin
            if (cnt_r == '0) begin
               state_nxt = SMCG_RUN;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
      endcase
   end

   // ****************************************
   // State and mode registers
   // ****************************************
   // The counter matters only in start-up and rests at zero elsewhere
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= SMCG_RUN;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // Mode is latched at entry so a later change cannot alter a sleep in progress
   // Held through start-up so the wake decode stays stable
   // mode captured on entry
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_r <= SMCG_MODE_RST;
      end else if (state_r == SMCG_RUN && enter) begin
         mode_r <= mode_sel;
      end
   end

   // ****************************************
   // Entry decode of the mode being latched
   // ****************************************
   // Same domain map as the latched mode, applied to the field before it is
   // captured, so the enables are right on the very first sleeping cycle.
   wire e_idle  = (mode_sel == SMCG_MODE_IDLE);
   wire e_adcnr = (mode_sel == SMCG_MODE_ADCNR);
   wire e_psave = (mode_sel == SMCG_MODE_PSAVE);
   wire e_stby  = (mode_sel == SMCG_MODE_STBY);
   wire e_xstby = (mode_sel == SMCG_MODE_XSTBY);

   wire e_io    = e_idle;
   wire e_adc   = e_idle || e_adcnr;
   wire e_tmr   = e_idle || e_adcnr || e_psave || e_xstby;
   wire e_osc   = e_idle || e_adcnr || e_stby || e_xstby;

   // ****************************************
   // Registered clock enables
   // ****************************************
   wire run_nxt   = (state_nxt == SMCG_RUN);
   wire sleep_nxt = (state_nxt == SMCG_SLEEP);
   wire in_run    = (state_r == SMCG_RUN);
   // Entry decode uses the mode being latched, not the stale one
   wire n_io  = in_run ? e_io  : keep_io;
   wire n_adc = in_run ? e_adc : keep_adc;
   wire n_tmr = in_run ? e_tmr : keep_tmr;
   wire n_osc = in_run ? e_osc : keep_osc;

   // Every domain runs unless the sequencer is heading into sleep; during the
   // start-up count all domains are back while the processor still waits.
   wire io_nxt     = !sleep_nxt || n_io;
   wire adc_nxt    = !sleep_nxt || n_adc;
   wire tmr_nxt    = !sleep_nxt || n_tmr;
   wire osc_on_nxt = !sleep_nxt || n_osc;
   wire resume_nxt = (state_r == SMCG_START) && run_nxt;

   // Out of reset every domain runs, as if just woken
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_clk_en       <= 1'b1;
         io_clk_en        <= 1'b1;
         adc_clk_en       <= 1'b1;
         tmr_async_clk_en <= 1'b1;
         osc_en           <= 1'b1;
         cpu_resume       <= 1'b0;
         asleep           <= 1'b0;
      end else begin
         // domains come back in start-up, before the CPU
         cpu_clk_en       <= run_nxt;
         io_clk_en        <= io_nxt;
         adc_clk_en       <= adc_nxt;
         tmr_async_clk_en <= tmr_nxt;
         // oscillator off while in power-down or power-save
         osc_en           <= osc_on_nxt;
         cpu_resume       <= resume_nxt;
         asleep           <= sleep_nxt;
      end
   end

endmodule

// ==== verification/smcg_assertions.sv ====
// Checker for the sleep mode clock gating block
module smcg_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic sleep_en,
   input wire logic sleep_req,
   input wire logic irq_async,
   input wire logic cpu_clk_en,
   input wire logic io_clk_en,
   input wire logic adc_clk_en,
   input wire logic tmr_async_clk_en,
   input wire logic osc_en,
   input wire logic cpu_resume,
   input wire logic asleep
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ****************************************
   // Properties
   // ****************************************
   sequence s_pd_quiet;
      asleep && !osc_en && !tmr_async_clk_en && !irq_async;
   endsequence
   sequence s_take;
      sleep_req && !asleep && cpu_clk_en;
   endsequence
   property p_take; s_take ##0 sleep_en |=> asleep; endproperty
   property p_no_en; s_take ##0 !sleep_en |=> !asleep; endproperty
   property p_cpu_off; asleep |-> !cpu_clk_en; endproperty
   property p_pd_all; asleep && !osc_en |-> !io_clk_en && !adc_clk_en; endproperty
   property p_pd_hold; s_pd_quiet [*5] |=> asleep; endproperty
   property p_wake; $fell(asleep) |-> ##[0:1] (io_clk_en && osc_en); endproperty
   property p_dom_first; cpu_resume |-> $past(io_clk_en) && $past(osc_en); endproperty
   property p_resume; $rose(cpu_clk_en) |-> cpu_resume ##1 !cpu_resume; endproperty
   a_take: assert property (p_take) else $error("sleep request not taken");
   a_no_en: assert property (p_no_en) else $error("sleep without enable");
   a_cpu_off: assert property (p_cpu_off) else $error("cpu clock runs asleep");
   a_pd_all: assert property (p_pd_all) else $error("domain runs in power-down");
   a_pd_hold: assert property (p_pd_hold) else $error("power-down left");
   a_wake: assert property (p_wake) else $error("domains late on wake");
   a_dom_first: assert property (p_dom_first) else $error("cpu before domains");
   a_resume: assert property (p_resume) else $error("resume pulse wrong");
endmodule

// ==== verification/sleep_mode_clock_gating_bench.sv ====
// Self-checking bench for the sleep mode clock gating block
module sleep_mode_clock_gating_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 0, rst = 1, sleep_en = 0, sleep_req = 0;
   logic [2:0] sleep_mode = 3'h0;
   logic       irq_async = 0, irq_sync = 0, timer_async_irq = 0, adc_done = 0;
   logic       cpu_clk_en, io_clk_en, adc_clk_en, tmr_async_clk_en, osc_en;
   logic       cpu_resume, asleep;
   int         mismatches = 0, cmp_count = 0;
   // Expected {asleep,cpu,io,adc,timer,osc} per mode code; 4 and 5 act as idle
   logic [5:0] rows [8] = '{6'h2f, 6'h27, 6'h20, 6'h22, 6'h2f, 6'h2f, 6'h21, 6'h23};
   wire  [5:0] st = {asleep, cpu_clk_en, io_clk_en, adc_clk_en, tmr_async_clk_en, osc_en};
   // Short start-up count keeps the run brief
   smcg_top #(.OSC_START_CYC(8)) dut (.clk(clk), .rst(rst), .sleep_mode(sleep_mode),
      .sleep_en(sleep_en), .sleep_req(sleep_req), .irq_async(irq_async),
      .irq_sync(irq_sync), .timer_async_irq(timer_async_irq), .adc_done(adc_done),
      .cpu_clk_en(cpu_clk_en), .io_clk_en(io_clk_en), .adc_clk_en(adc_clk_en),
      .tmr_async_clk_en(tmr_async_clk_en), .osc_en(osc_en), .cpu_resume(cpu_resume),
      .asleep(asleep));
   always #2 clk = ~clk;
   // ****************************************
   // Tasks
   // ****************************************
   task step; @(posedge clk); #1; endtask
   task tally_and_finish;
      if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task slp(input logic [2:0] m, input logic e);
      sleep_mode = m; sleep_en = e; sleep_req = 1; step;
      sleep_req = 0; step; step;
   endtask
   // Raises one wake source (0 sync irq, 1 pin irq, 2 async timer, 3 adc done)
   // and holds it until the cpu restarts, bounded
   task wake(input logic [1:0] a);
      int i;
      irq_sync = (a == 2'h0);
      irq_async = (a == 2'h1);
      timer_async_irq = (a == 2'h2);
      adc_done = (a == 2'h3);
      for (i = 0; i < 40 && cpu_resume !== 1'b1; i++) step;
      irq_async = 0;
      irq_sync = 0;
      timer_async_irq = 0;
      adc_done = 0;
      if (i == 40) begin
         mismatches++;
         tally_and_finish;
      end
      chk(st, 6'h1f);
      step;
      chk(cpu_resume, 1'b0);
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (12) step;
      rst = 0;
      step;
      chk({cpu_resume, st}, 7'h1f);
      for (int m = 0; m < 8; m++) begin
         slp(m[2:0], 1'b1);
         chk(st, rows[m]);
         wake(2'h1);
      end
      slp(3'h2, 1'b0);
      chk(st, 6'h1f);
      slp(3'h2, 1'b1);
      irq_sync = 1; timer_async_irq = 1; adc_done = 1;
      repeat (12) step;
      chk(st, 6'h20);
      irq_sync = 0; timer_async_irq = 0; adc_done = 0;
      wake(2'h1);
      slp(3'h0, 1'b1);
      wake(2'h0);
      slp(3'h0, 1'b1);
      wake(2'h3);
      slp(3'h1, 1'b1);
      wake(2'h3);
      slp(3'h3, 1'b1);
      wake(2'h2);
      slp(3'h7, 1'b1);
      wake(2'h2);
      slp(3'h6, 1'b1);
      irq_sync = 1;
      timer_async_irq = 1;
      adc_done = 1;
      repeat (4) step;
      chk(st, 6'h21);
      wake(2'h1);
      slp(3'h2, 1'b1);
      rst = 1; step; step;
      rst = 0; step;
      chk(st, 6'h1f);
      tally_and_finish;
   end
endmodule
bind smcg_top smcg_assertions u_chk (.clk(clk), .rst(rst), .sleep_en(sleep_en),
   .sleep_req(sleep_req), .irq_async(irq_async), .cpu_clk_en(cpu_clk_en),
   .io_clk_en(io_clk_en), .adc_clk_en(adc_clk_en), .tmr_async_clk_en(tmr_async_clk_en),
   .osc_en(osc_en), .cpu_resume(cpu_resume), .asleep(asleep));
